//--- core/feoq_map.svh
// Register fields, reset values and codes of the event qualifier
`ifndef FEOQ_MAP_SVH
`define FEOQ_MAP_SVH
`define FEOQ_SEL_MSB      7
`define FEOQ_SEL_LSB      0
`define FEOQ_LEN_MSB      19
`define FEOQ_LEN_LSB      8
`define FEOQ_WID_MSB      22
`define FEOQ_WID_LSB      20
`define FEOQ_FE_W         23
`define FEOQ_OFC_W        38
`define FEOQ_FE_MASK      23'h7FFFFF
`define FEOQ_OFC_MASK     38'h3FC45F8987
`define FEOQ_FE_RST       23'h000000
`define FEOQ_OFC_RST      38'h0000000000
`define FEOQ_SEL_BUBBLE   8'h06
`define FEOQ_SEL_MISS_LO  8'h11
`define FEOQ_SEL_MISS_HI  8'h15
`define FEOQ_SLOTS        3'h4
`define FEOQ_LINE_W       26
`define FEOQ_MISS_W       5
`define FEOQ_LF_DEPTH     8
`define FEOQ_LF_PTR_W     3
`define FEOQ_RUN_MAX      12'hFFF
`define FEOQ_RUN_ONE      12'h001
`define FEOQ_REQ_LOAD     0
`define FEOQ_REQ_RFO      1
`define FEOQ_REQ_CODE     2
`define FEOQ_REQ_PF_LOAD  7
`define FEOQ_REQ_PF_RFO   8
`define FEOQ_REQ_STREAM   11
`define FEOQ_REQ_OTHER    15
`define FEOQ_SUP_ANY      16
`define FEOQ_SUP_BASE     17
`define FEOQ_SUP_LLC_M    18
`endif

//--- core/feoq_pkg.sv
// Types shared by the event qualifier modules
`include "feoq_map.svh"
package feoq_pkg;
    typedef enum logic {
        FEOQ_MSR_FRONTEND = 1'b0,
        FEOQ_MSR_OFFCORE  = 1'b1
    } feoq_msr_t;
    typedef enum logic [3:0] {
        FEOQ_RQ_DMND_LOAD = 4'h0, FEOQ_RQ_DMND_PTE  = 4'h1,
        FEOQ_RQ_DMND_RFO  = 4'h2, FEOQ_RQ_DMND_CODE = 4'h3,
        FEOQ_RQ_L1_CODEPF = 4'h4, FEOQ_RQ_MLC_LOAD  = 4'h5,
        FEOQ_RQ_MLC_RFO   = 4'h6, FEOQ_RQ_STREAM_ST = 4'h7,
        FEOQ_RQ_IO        = 4'h8, FEOQ_RQ_HW_PF     = 4'h9,
        FEOQ_RQ_SW_PF     = 4'hA, FEOQ_RQ_L2_RFOPF  = 4'hB,
        FEOQ_RQ_L2_CODEPF = 4'hC, FEOQ_RQ_OTHER     = 4'hD
    } feoq_req_t;
    typedef enum logic [2:0] {
        FEOQ_SP_NONE  = 3'h0, FEOQ_SP_LLC_M = 3'h1, FEOQ_SP_LLC_E = 3'h2,
        FEOQ_SP_LLC_S = 3'h3, FEOQ_SP_L4    = 3'h4, FEOQ_SP_DRAM  = 3'h5,
        FEOQ_SP_L4SPL = 3'h6, FEOQ_SP_OTHER = 3'h7
    } feoq_sup_t;
    typedef struct packed {
        logic [2:0] filled;
        logic       be_stall;
    } feoq_alloc_t;
    typedef struct packed {
        logic                       valid;
        logic                       wrong_path;
        logic                       last_uop;
        logic                       straddle;
        logic [`FEOQ_MISS_W-1:0]    miss_vec;
        logic [`FEOQ_LINE_W-1:0]    line_a;
        logic [`FEOQ_LINE_W-1:0]    line_b;
    } feoq_retire_t;
    typedef struct packed {
        logic      valid;
        feoq_req_t req;
        feoq_sup_t sup;
    } feoq_rsp_t;
endpackage : feoq_pkg

//--- core/feoq_bubble_run.sv
// Decode-queue gap run detector
`include "feoq_map.svh"
module feoq_bubble_run (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire feoq_pkg::feoq_alloc_t alloc,
    input  wire logic [11:0]          run_length,
    input  wire logic [2:0]           slot_count,
    output logic                      fire
);
    logic [11:0] run_cnt_reg;
    logic [2:0]  gap;
    logic        qual;
    logic [11:0] len_eff;

    assign gap     = alloc.be_stall ? 3'h0 : 3'(`FEOQ_SLOTS - alloc.filled); // RQ2
    assign qual    = !alloc.be_stall && (gap >= slot_count); // RQ4
    assign len_eff = (run_length == 12'h000) ? `FEOQ_RUN_ONE : run_length; // RQ3
    assign fire    = qual && (12'(run_cnt_reg + `FEOQ_RUN_ONE) == len_eff); // RQ5

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            run_cnt_reg <= 12'h000;
        end else if (clk_en) begin
            if (!qual) begin
                run_cnt_reg <= 12'h000; // RQ5
            end else if (run_cnt_reg != `FEOQ_RUN_MAX) begin
                run_cnt_reg <= 12'(run_cnt_reg + `FEOQ_RUN_ONE);
            end
        end
    end

    property p_run_break;
        @(posedge clock) disable iff (!reset_n) clk_en && !qual |=> run_cnt_reg == 12'h000;
    endproperty
    a_run_break: assert property (p_run_break) else $error("run not broken"); // RQ5
    property p_stall_no_gap;
        @(posedge clock) disable iff (!reset_n) alloc.be_stall |-> !qual && gap == 3'h0;
    endproperty
    a_stall_no_gap: assert property (p_stall_no_gap) else $error("gap under stall"); // RQ2
endmodule : feoq_bubble_run

//--- core/feoq_line_filter.sv
// Recently counted cacheline memory
`include "feoq_map.svh"
module feoq_line_filter (
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire logic                    flush,
    input  wire logic [`FEOQ_LINE_W-1:0] look_line,
    output logic                         look_hit,
    input  wire logic                    ins_a,
    input  wire logic                    ins_b,
    input  wire logic [`FEOQ_LINE_W-1:0] line_a,
    input  wire logic [`FEOQ_LINE_W-1:0] line_b
);
    logic [`FEOQ_LINE_W-1:0]   tag_reg [`FEOQ_LF_DEPTH];
    logic [`FEOQ_LF_DEPTH-1:0] vld_reg;
    logic [`FEOQ_LF_PTR_W-1:0] ptr_reg;
    logic [`FEOQ_LF_PTR_W-1:0] ptr_b;

    assign ptr_b = ins_a ? 3'(ptr_reg + 3'h1) : ptr_reg;

    always_comb begin
        look_hit = 1'b0;
        for (int i = 0; i < `FEOQ_LF_DEPTH; i++) begin
            if (vld_reg[i] && tag_reg[i] == look_line) look_hit = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n || (clk_en && flush)) begin
            vld_reg <= '0;
            ptr_reg <= '0;
        end else if (clk_en) begin
            if (ins_a) begin
                tag_reg[ptr_reg] <= line_a;
                vld_reg[ptr_reg] <= 1'b1;
            end
            if (ins_b) begin
                tag_reg[ptr_b] <= line_b;
                vld_reg[ptr_b] <= 1'b1;
            end
            ptr_reg <= 3'(ptr_reg + 3'(ins_a) + 3'(ins_b));
        end
    end
endmodule : feoq_line_filter

//--- core/feoq_top.sv
// Front-end and off-core event qualifier
`include "feoq_map.svh"

// Summary of operation
// RQ1: Bits 7:0 pick the front-end condition; 6H selects decode-queue gaps.
// RQ2: Each of four unfilled slots in an unstalled cycle is a gap.
// RQ3: Bits 19:8 give least run of consecutive qualifying cycles.
// RQ4: Bits 22:20 give least empty slots a cycle needs to qualify.
// RQ5: Count only after run-length consecutive cycles each with enough gaps.
// RQ6: Count only retired correct-path instructions; drop wrong-path conditions.
// RQ7: Count a front-end miss at most once per cacheline.
// RQ8: A line-straddling instruction counts once; second line misses ignored.
// RQ9: Gaps of a wide multi-uop instruction count once for it.
// RQ10: A macro-fused pair counts once when either member misses.
// RQ11: A miss outside an instruction boundary goes to next retiring instruction.
// RQ12: Only the first miss to a line is a true miss.
// RQ13: Software lays out request, supplier and snoop fields of the filter.
// RQ14: Bit 0 matches demand loads and table walks, not prefetches.
// RQ15: Bit 1 matches demand ownership reads, not second-level prefetches.
// RQ16: Bit 2 matches demand and first-level code fetches, not L2 prefetches.
// RQ17: Bits 7 and 8 match mid-cache prefetch loads and ownership requests.
// RQ18: Bit 11 matches streaming writes; bit 15 any other request.
// RQ19: Bit 16 matches any response; bit 17 responses lacking supplier.
// RQ20: Bits 18, 19, 20 match modified, exclusive, shared LLC hits.
// RQ21: Bits 22, 26, 30 match Fourth_level_hit, local memory, L4 superline.
// RQ22: Software selects event C6H umask 01H before using the qualifier.
// RQ23: The all-threads qualifier bit is ignored for the front-end event.
// RQ24: Reserved bits read zero and ignore writes.
// RQ25: One-cycle count pulse per qualifying event using current settings.
module feoq_top (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   clk_en,
    input  wire logic                   msr_wr_en,
    input  wire logic                   msr_rd_en,
    input  wire feoq_pkg::feoq_msr_t    msr_sel,
    input  wire logic [63:0]            msr_wdata,
    output logic [63:0]                 msr_rdata,
    input  wire logic                   fe_event_selected,
    input  wire feoq_pkg::feoq_alloc_t  alloc,
    input  wire feoq_pkg::feoq_retire_t retire,
    input  wire logic                   oob_miss,
    input  wire feoq_pkg::feoq_rsp_t    rsp,
    output logic                        fe_count,
    output logic                        ofc_count
);
    logic [`FEOQ_FE_W-1:0]  fe_qual_reg;
    logic [`FEOQ_OFC_W-1:0] ofc_filt_reg;
    logic [63:0]            msr_rdata_reg;
    logic                   pend_bub_reg;
    logic                   pend_oob_reg;
    logic                   fe_count_reg;
    logic                   ofc_count_reg;

    logic [7:0]  sel;
    logic [11:0] run_length;
    logic [2:0]  slot_count;
    logic        is_bubble;
    logic        is_miss;
    logic        bub_fire;
    logic        line_hit;
    logic        ret_final;
    logic        miss_raw;
    logic        miss_true;
    logic        fe_hit;
    logic        ofc_hit;
    logic        fe_wr;

    // Decoding helpers
    function automatic logic miss_of(input logic [7:0] s,
                                     input logic [`FEOQ_MISS_W-1:0] v);
        logic [7:0] idx;
        idx = 8'(s - `FEOQ_SEL_MISS_LO);
        miss_of = 1'b0;
        if (s >= `FEOQ_SEL_MISS_LO && s <= `FEOQ_SEL_MISS_HI) begin
            miss_of = v[idx[2:0]];
        end
    endfunction : miss_of

    function automatic logic [15:0] req_hot(input feoq_pkg::feoq_req_t r);
        req_hot = 16'h0000;
        unique case (r)
            feoq_pkg::FEOQ_RQ_DMND_LOAD,
            feoq_pkg::FEOQ_RQ_DMND_PTE:  req_hot[`FEOQ_REQ_LOAD] = 1'b1; // RQ14
            feoq_pkg::FEOQ_RQ_DMND_RFO:  req_hot[`FEOQ_REQ_RFO] = 1'b1; // RQ15
            feoq_pkg::FEOQ_RQ_DMND_CODE,
            feoq_pkg::FEOQ_RQ_L1_CODEPF: req_hot[`FEOQ_REQ_CODE] = 1'b1; // RQ16
            feoq_pkg::FEOQ_RQ_MLC_LOAD:  req_hot[`FEOQ_REQ_PF_LOAD] = 1'b1; // RQ17
            feoq_pkg::FEOQ_RQ_MLC_RFO:   req_hot[`FEOQ_REQ_PF_RFO] = 1'b1; // RQ17
            feoq_pkg::FEOQ_RQ_STREAM_ST: req_hot[`FEOQ_REQ_STREAM] = 1'b1; // RQ18
            default:                     req_hot[`FEOQ_REQ_OTHER] = 1'b1; // RQ18
        endcase
    endfunction : req_hot

    function automatic logic [14:0] sup_hot(input feoq_pkg::feoq_sup_t p);
        sup_hot = 15'h0000;
        unique case (p)
            feoq_pkg::FEOQ_SP_NONE:  sup_hot[1] = 1'b1; // RQ19
            feoq_pkg::FEOQ_SP_LLC_M: sup_hot[2] = 1'b1; // RQ20
            feoq_pkg::FEOQ_SP_LLC_E: sup_hot[3] = 1'b1; // RQ20
            feoq_pkg::FEOQ_SP_LLC_S: sup_hot[4] = 1'b1; // RQ20
            feoq_pkg::FEOQ_SP_L4:    sup_hot[6] = 1'b1; // RQ21
            feoq_pkg::FEOQ_SP_DRAM:  sup_hot[10] = 1'b1; // RQ21
            feoq_pkg::FEOQ_SP_L4SPL: sup_hot[14] = 1'b1; // RQ21
            feoq_pkg::FEOQ_SP_OTHER: sup_hot = 15'h0000;
        endcase
    endfunction : sup_hot

    // Field views of the front-end qualifier
    assign sel        = fe_qual_reg[`FEOQ_SEL_MSB:`FEOQ_SEL_LSB]; // RQ1
    assign run_length = fe_qual_reg[`FEOQ_LEN_MSB:`FEOQ_LEN_LSB]; // RQ3
    assign slot_count = fe_qual_reg[`FEOQ_WID_MSB:`FEOQ_WID_LSB]; // RQ4
    assign is_bubble  = (sel == `FEOQ_SEL_BUBBLE); // RQ1
    assign is_miss    = (sel >= `FEOQ_SEL_MISS_LO) && (sel <= `FEOQ_SEL_MISS_HI);
    assign fe_wr      = msr_wr_en && (msr_sel == feoq_pkg::FEOQ_MSR_FRONTEND);

    feoq_bubble_run u_bubble (
        .clock      (clock),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .alloc      (alloc),
        .run_length (run_length),
        .slot_count (slot_count),
        .fire       (bub_fire)
    );

    // An instruction may retire as several records, last_uop on the final one; a fused pair retires as a single record
    assign ret_final = retire.valid && retire.last_uop && !retire.wrong_path; // RQ6 RQ10
    assign miss_raw  = miss_of(sel, retire.miss_vec) || pend_oob_reg; // RQ10 RQ11
    assign miss_true = miss_raw && !line_hit; // RQ7 RQ12

    feoq_line_filter u_lines (
        .clock     (clock),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .flush     (fe_wr),
        .look_line (retire.line_a),
        .look_hit  (line_hit),
        .ins_a     (ret_final && is_miss && miss_raw), // RQ7
        .ins_b     (ret_final && is_miss && miss_raw && retire.straddle), // RQ8
        .line_a    (retire.line_a),
        .line_b    (retire.line_b)
    );

    // All-threads qualifier is not an input: only this thread's retirement counts
    always_comb begin
        fe_hit = 1'b0;
        if (fe_event_selected && ret_final) begin // RQ22 RQ23
            if (is_bubble) begin
                fe_hit = pend_bub_reg || bub_fire; // RQ9
            end else if (is_miss) begin
                fe_hit = miss_true; // RQ7 RQ8
            end
        end
    end

    // Filter match is request class AND supplier; snoop field is stored only
    assign ofc_hit = rsp.valid
                     && |(req_hot(rsp.req) & ofc_filt_reg[15:0]) // RQ13
                     && (ofc_filt_reg[`FEOQ_SUP_ANY] // RQ19
                         || |(sup_hot(rsp.sup) & ofc_filt_reg[30:16]));

    // Register writes
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fe_qual_reg <= `FEOQ_FE_RST;
        end else if (clk_en && fe_wr) begin
            fe_qual_reg <= msr_wdata[`FEOQ_FE_W-1:0] & `FEOQ_FE_MASK; // RQ24
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ofc_filt_reg <= `FEOQ_OFC_RST;
        end else if (clk_en && msr_wr_en && msr_sel == feoq_pkg::FEOQ_MSR_OFFCORE) begin
            ofc_filt_reg <= msr_wdata[`FEOQ_OFC_W-1:0] & `FEOQ_OFC_MASK; // RQ24
        end
    end

    // Register reads
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            msr_rdata_reg <= 64'h0000000000000000;
        end else if (clk_en && msr_rd_en) begin
            if (msr_sel == feoq_pkg::FEOQ_MSR_FRONTEND) begin
                msr_rdata_reg <= {41'h0, fe_qual_reg}; // RQ24
            end else begin
                msr_rdata_reg <= {26'h0, ofc_filt_reg}; // RQ24
            end
        end
    end

    // A run that completes waits for the next final retirement; clear beats set
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pend_bub_reg <= 1'b0;
        end else if (clk_en) begin
            if (fe_wr) begin
                pend_bub_reg <= 1'b0;
            end else if (bub_fire && !ret_final) begin
                pend_bub_reg <= 1'b1; // RQ9 RQ11
            end else if (ret_final) begin
                pend_bub_reg <= 1'b0; // RQ9
            end
        end
    end

    // Miss outside any instruction is carried to the next retirement
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pend_oob_reg <= 1'b0;
        end else if (clk_en) begin
            if (oob_miss) begin
                pend_oob_reg <= 1'b1; // RQ11
            end else if (ret_final) begin
                pend_oob_reg <= 1'b0;
            end
        end
    end

    // Count pulses
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fe_count_reg <= 1'b0;
        end else if (clk_en) begin
            fe_count_reg <= fe_hit; // RQ25
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ofc_count_reg <= 1'b0;
        end else if (clk_en) begin
            ofc_count_reg <= ofc_hit; // RQ25
        end
    end

    assign msr_rdata = msr_rdata_reg;
    assign fe_count  = fe_count_reg && clk_en;
    assign ofc_count = ofc_count_reg && clk_en;

    // Checks
    property p_rsvd_zero;
        @(posedge clock) disable iff (!reset_n)
        clk_en && msr_rd_en && msr_sel == feoq_pkg::FEOQ_MSR_FRONTEND
        |=> msr_rdata_reg[63:23] == 41'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // RQ24

    property p_fe_cause;
        @(posedge clock) disable iff (!reset_n) clk_en && fe_hit |=> fe_count_reg;
    endproperty
    a_fe_cause: assert property (p_fe_cause) else $error("front-end count lost"); // RQ25

    property p_wrong_path;
        @(posedge clock) disable iff (!reset_n)
        clk_en && !(retire.valid && retire.last_uop && !retire.wrong_path)
        |=> !fe_count_reg;
    endproperty
    a_wrong_path: assert property (p_wrong_path) else $error("count without retire"); // RQ6

    property p_line_once;
        @(posedge clock) disable iff (!reset_n)
        (clk_en && fe_hit && is_miss && !fe_wr)
        ##1 (clk_en && retire.line_a == $past(retire.line_a))
        |=> !fe_count_reg;
    endproperty
    a_line_once: assert property (p_line_once) else $error("line counted twice"); // RQ7

    property p_bubble_once;
        @(posedge clock) disable iff (!reset_n)
        clk_en && fe_hit && is_bubble && !bub_fire |=> !pend_bub_reg;
    endproperty
    a_bubble_once: assert property (p_bubble_once) else $error("gap event reused"); // RQ9

    property p_sel_unknown;
        @(posedge clock) disable iff (!reset_n)
        clk_en && !is_bubble && !is_miss |=> !fe_count_reg;
    endproperty
    a_sel_unknown: assert property (p_sel_unknown) else $error("count on bad select"); // RQ1

    property p_oob_carry;
        @(posedge clock) disable iff (!reset_n)
        clk_en && oob_miss |=> pend_oob_reg;
    endproperty
    a_oob_carry: assert property (p_oob_carry) else $error("stray miss lost"); // RQ11

    property p_dmnd_load;
        @(posedge clock) disable iff (!reset_n)
        clk_en && rsp.valid && rsp.req == feoq_pkg::FEOQ_RQ_DMND_LOAD
        && ofc_filt_reg[`FEOQ_REQ_LOAD] && ofc_filt_reg[`FEOQ_SUP_ANY]
        |=> ofc_count_reg;
    endproperty
    a_dmnd_load: assert property (p_dmnd_load) else $error("demand load missed"); // RQ14

    property p_pf_excluded;
        @(posedge clock) disable iff (!reset_n)
        clk_en && rsp.valid && rsp.req == feoq_pkg::FEOQ_RQ_HW_PF
        && !ofc_filt_reg[`FEOQ_REQ_OTHER] |=> !ofc_count_reg;
    endproperty
    a_pf_excluded: assert property (p_pf_excluded) else $error("prefetch matched"); // RQ14

    property p_no_sup;
        @(posedge clock) disable iff (!reset_n)
        clk_en && rsp.valid && !ofc_filt_reg[`FEOQ_SUP_ANY]
        && ofc_filt_reg[30:16] == 15'h0000 |=> !ofc_count_reg;
    endproperty
    a_no_sup: assert property (p_no_sup) else $error("no supplier bit matched"); // RQ19

    c_bubble: cover property (@(posedge clock) disable iff (!reset_n)
        clk_en && fe_hit && is_bubble);
    c_miss: cover property (@(posedge clock) disable iff (!reset_n)
        clk_en && fe_hit && is_miss && retire.straddle);
    c_ofc: cover property (@(posedge clock) disable iff (!reset_n)
        clk_en && ofc_hit);
    c_stray: cover property (@(posedge clock) disable iff (!reset_n)
        clk_en && fe_hit && pend_oob_reg);
    c_line_skip: cover property (@(posedge clock) disable iff (!reset_n)
        clk_en && ret_final && is_miss && miss_raw && line_hit);

    property p_ofc_cause;
        @(posedge clock) disable iff (!reset_n) clk_en && ofc_hit |=> ofc_count_reg;
    endproperty
    a_ofc_cause: assert property (p_ofc_cause) else $error("off-core count lost"); // RQ25

    property p_sup_none;
        @(posedge clock) disable iff (!reset_n)
        clk_en && rsp.valid && rsp.sup == feoq_pkg::FEOQ_SP_NONE
        && |(req_hot(rsp.req) & ofc_filt_reg[15:0]) && ofc_filt_reg[`FEOQ_SUP_BASE]
        |=> ofc_count_reg;
    endproperty
    a_sup_none: assert property (p_sup_none) else $error("no-supplier miss lost"); // RQ19

    property p_llc_mod;
        @(posedge clock) disable iff (!reset_n)
        clk_en && rsp.valid && rsp.sup == feoq_pkg::FEOQ_SP_LLC_M
        && |(req_hot(rsp.req) & ofc_filt_reg[15:0]) && ofc_filt_reg[`FEOQ_SUP_LLC_M]
        |=> ofc_count_reg;
    endproperty
    a_llc_mod: assert property (p_llc_mod) else $error("modified hit missed"); // RQ20

    property p_run_pend;
        @(posedge clock) disable iff (!reset_n)
        clk_en && bub_fire && !ret_final && !fe_wr |=> pend_bub_reg;
    endproperty
    a_run_pend: assert property (p_run_pend) else $error("completed run dropped"); // RQ9
endmodule : feoq_top

//--- test/feoq_core_model.sv
// Core pipeline and memory hierarchy model driving the qualifier inputs
`include "feoq_map.svh"
module feoq_core_model (
    input  wire logic              clock,
    output feoq_pkg::feoq_alloc_t  alloc,
    output feoq_pkg::feoq_retire_t retire,
    output logic                   oob_miss,
    output feoq_pkg::feoq_rsp_t    rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        alloc = '{filled: 3'h4, be_stall: 1'b0};
        retire = '0;
        oob_miss = 1'b0;
        rsp = '0;
    end
    // Hold one slot pattern for n cycles, then refill every slot
    task automatic gaps(input logic [2:0] f, input logic st, input int n);
        alloc = '{filled: f, be_stall: st};
        repeat (n) @(negedge clock);
        alloc = '{filled: 3'h4, be_stall: 1'b0};
    endtask : gaps
    // Two short runs split by one stalled cycle with the same slot pattern
    task automatic broken_run(input logic [2:0] f, input int n);
        alloc = '{filled: f, be_stall: 1'b0};
        repeat (n) @(negedge clock);
        alloc = '{filled: f, be_stall: 1'b1};
        @(negedge clock);
        alloc = '{filled: f, be_stall: 1'b0};
        repeat (n) @(negedge clock);
        alloc = '{filled: 3'h4, be_stall: 1'b0};
    endtask : broken_run
    // One retirement record; a fused pair travels as one record
    task automatic ret(input logic wp, lst, sd, input logic [4:0] v,
                       input logic [`FEOQ_LINE_W-1:0] la, lb);
        retire = '{1'b1, wp, lst, sd, v, la, lb};
        @(negedge clock);
    endtask : ret
    // Released fields show junk rather than the last record; one idle cycle
    task automatic rest();
        retire = {1'b0, ~retire[59:0]};
        @(negedge clock);
    endtask : rest
    task automatic oob();
        oob_miss = 1'b1;
        @(negedge clock);
        oob_miss = 1'b0;
    endtask : oob
    task automatic resp(input feoq_pkg::feoq_req_t r, input feoq_pkg::feoq_sup_t s);
        rsp = '{1'b1, r, s};
        @(negedge clock);
        rsp = {1'b0, ~rsp[6:0]};
    endtask : resp
endmodule : feoq_core_model

//--- test/feoq_top_bench.sv
// Self-checking bench for the event qualifier
module feoq_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clock = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   msr_wr_en = 1'b0;
    logic                   msr_rd_en = 1'b0;
    feoq_pkg::feoq_msr_t    msr_sel = feoq_pkg::FEOQ_MSR_FRONTEND;
    logic [63:0]            msr_wdata = 64'h0;
    logic [63:0]            msr_rdata;
    logic                   fe_event_selected = 1'b1;
    feoq_pkg::feoq_alloc_t  alloc;
    feoq_pkg::feoq_retire_t retire;
    logic                   oob_miss;
    feoq_pkg::feoq_rsp_t    rsp;
    logic                   fe_count;
    logic                   ofc_count;
    int                     n_fail = 0;
    int                     checks = 0;
    int                     rb[14] = '{0, 0, 1, 2, 2, 7, 8, 11, 15, 15, 15, 15, 15, 15};
    int                     sb[8] = '{17, 18, 19, 20, 22, 26, 30, 16};
    localparam feoq_pkg::feoq_msr_t FE = feoq_pkg::FEOQ_MSR_FRONTEND;
    localparam feoq_pkg::feoq_msr_t OF = feoq_pkg::FEOQ_MSR_OFFCORE;

    always #2.5 clock = ~clock;

    feoq_top u_dut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
        .msr_wr_en(msr_wr_en), .msr_rd_en(msr_rd_en), .msr_sel(msr_sel),
        .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
        .fe_event_selected(fe_event_selected), .alloc(alloc), .retire(retire),
        .oob_miss(oob_miss), .rsp(rsp), .fe_count(fe_count), .ofc_count(ofc_count));

    feoq_core_model u_core (.clock(clock), .alloc(alloc), .retire(retire),
        .oob_miss(oob_miss), .rsp(rsp));

    task automatic check(input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic ck1(input logic seen, exp);
        check({63'h0, seen}, {63'h0, exp});
    endtask : ck1
    task automatic wr(input feoq_pkg::feoq_msr_t s, input logic [63:0] d);
        msr_sel = s;
        msr_wdata = d;
        msr_wr_en = 1'b1;
        @(negedge clock);
        msr_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input feoq_pkg::feoq_msr_t s, input logic [63:0] e);
        msr_sel = s;
        msr_rd_en = 1'b1;
        @(negedge clock);
        msr_rd_en = 1'b0;
        check(msr_rdata, e);
    endtask : rd
    task automatic fe(input logic wp, lst, sd, input logic [4:0] v,
                      input logic [25:0] la, lb, input logic e);
        u_core.ret(wp, lst, sd, v, la, lb);
        ck1(fe_count, e);
        u_core.rest();
    endtask : fe
    task automatic oc(input int r, s, input logic e);
        u_core.resp(feoq_pkg::feoq_req_t'(4'(r)), feoq_pkg::feoq_sup_t'(3'(s)));
        ck1(ofc_count, e);
    endtask : oc
    task automatic results();
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        results();
    end

    initial begin
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        rd(FE, 64'h0);
        @(negedge clock);
        rd(OF, 64'h0);
        wr(FE, {64{1'b1}});
        rd(FE, 64'h7FFFFF);
        wr(OF, {64{1'b1}});
        rd(OF, 64'h3FC45F8987);
        // Gap event: run of 3 cycles, at least 2 empty slots
        wr(FE, 64'h200306);
        u_core.gaps(3'h2, 1'b0, 3);
        fe(0, 1, 0, 5'h0, 26'h10, 26'h11, 1);
        ck1(fe_count, 1'b0);
        u_core.gaps(3'h2, 1'b0, 2);
        fe(0, 1, 0, 5'h0, 26'h12, 26'h13, 0);
        u_core.gaps(3'h3, 1'b0, 3);
        fe(0, 1, 0, 5'h0, 26'h14, 26'h15, 0);
        u_core.broken_run(3'h2, 2);
        fe(0, 1, 0, 5'h0, 26'h16, 26'h17, 0);
        u_core.gaps(3'h2, 1'b0, 3);
        fe(0, 0, 0, 5'h0, 26'h18, 26'h19, 0);
        fe(1, 1, 0, 5'h0, 26'h1A, 26'h1B, 0);
        fe(0, 1, 0, 5'h0, 26'h1C, 26'h1D, 1);
        fe(0, 1, 0, 5'h0, 26'h1E, 26'h1F, 0);
        // Miss sub-events: each select counts its own miss only
        for (int i = 0; i < 5; i++) begin
            wr(FE, 64'h11 + 64'(i));
            fe(0, 1, 0, ~(5'h01 << i), 26'h20 + 26'(i), 26'h0, 0);
            fe(0, 1, 0, 5'h01 << i, 26'h30 + 26'(i), 26'h0, 1);
        end
        wr(FE, 64'h12);
        u_core.ret(0, 1, 0, 5'h02, 26'h100, 26'h0);
        ck1(fe_count, 1'b1);
        fe(0, 1, 0, 5'h02, 26'h100, 26'h0, 0);
        fe(0, 1, 1, 5'h02, 26'h200, 26'h201, 1);
        fe(0, 1, 0, 5'h02, 26'h201, 26'h0, 0);
        fe(0, 1, 0, 5'h06, 26'h300, 26'h0, 1);
        ck1(fe_count, 1'b0);
        fe(1, 1, 0, 5'h02, 26'h400, 26'h0, 0);
        u_core.oob();
        fe(0, 1, 0, 5'h00, 26'h500, 26'h0, 1);
        fe_event_selected = 1'b0;
        fe(0, 1, 0, 5'h02, 26'h600, 26'h0, 0);
        fe_event_selected = 1'b1;
        // Off-core request classes, one enabling bit each
        for (int i = 0; i < 14; i++) begin
            wr(OF, (64'h1 << rb[i]) | 64'h10000);
            oc(i, 7, 1);
            wr(OF, (64'h8987 & ~(64'h1 << rb[i])) | 64'h10000);
            oc(i, 7, 0);
        end
        // Supplier classes on demand loads
        for (int s = 0; s < 8; s++) begin
            wr(OF, 64'h1 | (64'h1 << sb[s]));
            oc(0, s, 1);
            wr(OF, 64'h1 | (64'h445E0000 & ~(64'h1 << sb[s])));
            oc(0, s, 0);
        end
        wr(OF, 64'h1);
        oc(0, 0, 0);
        results();
    end
endmodule : feoq_top_bench
